/* File: shared/hbs_pkg.sv */
// Constants, types and register map of the H-bridge mode controller.
// Assumes one 200 MHz clock and an AXI4-Lite register bus.
`default_nettype none
package hbs_pkg;

	// ******************************
	// Register map
	// ******************************
	localparam int               ADDR_W       = 5;
	localparam logic [4:0]       OFS_CTRL     = 5'h00;
	localparam logic [4:0]       OFS_STATUS   = 5'h04;
	localparam logic [4:0]       OFS_IRQ_STS  = 5'h08;
	localparam logic [4:0]       OFS_IRQ_MASK = 5'h0c;
	localparam logic [1:0]       RESP_OKAY    = 2'h0;
	localparam logic [1:0]       RESP_SLVERR  = 2'h2;

	// Field positions
	localparam int               CTRL_SLEEP_BIT = 0;
	localparam int               IRQ_W          = 5;
	localparam int               IRQ_SLEEP      = 0;
	localparam int               IRQ_WAKE       = 1;
	localparam int               IRQ_UV         = 2;
	localparam int               IRQ_OC         = 3;
	localparam int               IRQ_OT         = 4;
	localparam int               STS_STATE_LSB  = 0;
	localparam int               STS_MODE_LSB   = 3;
	localparam int               STS_UV_BIT     = 5;
	localparam int               STS_OC_BIT     = 6;
	localparam int               STS_OT_BIT     = 7;
	localparam int               STS_PIN_BIT    = 8;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST   = 5'h00;

	// ******************************
	// Timing
	// ******************************
	localparam int unsigned CLK_MHZ       = 200;
	localparam int unsigned SLEEP_TIME_US = 1000;
	localparam int unsigned WAKE_TIME_US  = 50;
	localparam int unsigned RETRY_TIME_US = 1000;
	localparam int unsigned SLEEP_CYC     = SLEEP_TIME_US * CLK_MHZ;
	localparam int unsigned WAKE_CYC      = WAKE_TIME_US * CLK_MHZ;
	localparam int unsigned RETRY_CYC     = RETRY_TIME_US * CLK_MHZ;
	localparam int          TMR_W         = 24;

	// ******************************
	// Types
	// ******************************
	typedef enum logic [2:0] {
		HBS_ACTIVE = 3'b000,
		HBS_IDLE   = 3'b001,
		HBS_SLEEP  = 3'b010,
		HBS_WAKE   = 3'b011,
		HBS_FAULT  = 3'b100
	} hbs_state_t;

	typedef enum logic [1:0] {
		MODE_PWM  = 2'b00,
		MODE_PHEN = 2'b01,
		MODE_HALF = 2'b10
	} hbs_mode_t;

	typedef struct packed {
		logic out_a_high;
		logic out_a_low;
		logic out_b_high;
		logic out_b_low;
	} hbs_bridge_t;

	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       data;
		logic [3:0]        strb;
	} hbs_regacc_t;

	typedef struct packed {
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic              wr_fire;
	} hbs_axs_st_t;

	// Mapped word address check
	function automatic logic hbs_addr_ok(input logic [ADDR_W-1:0] a);
		return (a == OFS_CTRL) || (a == OFS_STATUS) ||
			(a == OFS_IRQ_STS) || (a == OFS_IRQ_MASK);
	endfunction : hbs_addr_ok

endpackage : hbs_pkg
`default_nettype wire

/* File: core/hbs_timer.sv */
// Down counter giving a one-cycle done pulse after a loaded length.
// Assumes start is a one-cycle pulse; start reloads a running count.
`timescale 1ns/1ps
`default_nettype none
module hbs_timer #(
	parameter int W = 24
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         start,
	input  wire logic [W-1:0] len,
	output logic              done
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} hbs_tmr_st_t;

	hbs_tmr_st_t s_r;
	hbs_tmr_st_t s_nxt;

	// Reload or count toward zero
	always_comb
	begin
		s_nxt = s_r;
		if (start)
			s_nxt.cnt = len;
		else if (s_r.cnt != '0)
			s_nxt.cnt = s_r.cnt - W'(1);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign done = (s_r.cnt == W'(1)) && !start; // Last count reached

endmodule : hbs_timer
`default_nettype wire

/* File: core/hbs_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes read data is decoded combinationally from rd_addr.
`timescale 1ns/1ps
`default_nettype none
module hbs_axil_slave (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic [hbs_pkg::ADDR_W-1:0] s_axil_awaddr,
	input  wire logic                     s_axil_awvalid,
	output logic                          s_axil_awready,
	input  wire logic [31:0]              s_axil_wdata,
	input  wire logic [3:0]               s_axil_wstrb,
	input  wire logic                     s_axil_wvalid,
	output logic                          s_axil_wready,
	output logic [1:0]                    s_axil_bresp,
	output logic                          s_axil_bvalid,
	input  wire logic                     s_axil_bready,
	input  wire logic [hbs_pkg::ADDR_W-1:0] s_axil_araddr,
	input  wire logic                     s_axil_arvalid,
	output logic                          s_axil_arready,
	output logic [31:0]                   s_axil_rdata,
	output logic [1:0]                    s_axil_rresp,
	output logic                          s_axil_rvalid,
	input  wire logic                     s_axil_rready,
	output hbs_pkg::hbs_regacc_t          wr,
	output logic [hbs_pkg::ADDR_W-1:0]    rd_addr,
	input  wire logic [31:0]              rd_data
);

	hbs_pkg::hbs_axs_st_t s_r;
	hbs_pkg::hbs_axs_st_t s_nxt;

	// Channel readies
	assign s_axil_awready = !s_r.aw_got && !s_r.bvalid;
	assign s_axil_wready  = !s_r.w_got && !s_r.bvalid;
	assign s_axil_arready = !s_r.rvalid;

	// Collect address and data in either order, then answer
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.wr_fire = 1'b0;
		if (s_axil_awvalid && s_axil_awready)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axil_awaddr;
		end
		if (s_axil_wvalid && s_axil_wready)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axil_wdata;
			s_nxt.wstrb = s_axil_wstrb;
		end
		if (s_nxt.aw_got && s_nxt.w_got)
		begin
			s_nxt.aw_got  = 1'b0;
			s_nxt.w_got   = 1'b0;
			s_nxt.wr_fire = 1'b1;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = hbs_pkg::hbs_addr_ok(s_nxt.awaddr) ?
				hbs_pkg::RESP_OKAY : hbs_pkg::RESP_SLVERR;
		end
		else if (s_r.bvalid && s_axil_bready)
			s_nxt.bvalid = 1'b0;
		if (s_axil_arvalid && s_axil_arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rd_data;
			s_nxt.rresp  = hbs_pkg::hbs_addr_ok(s_axil_araddr) ?
				hbs_pkg::RESP_OKAY : hbs_pkg::RESP_SLVERR;
		end
		else if (s_r.rvalid && s_axil_rready)
			s_nxt.rvalid = 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign s_axil_bvalid = s_r.bvalid;
	assign s_axil_bresp  = s_r.bresp;
	assign s_axil_rvalid = s_r.rvalid;
	assign s_axil_rresp  = s_r.rresp;
	assign s_axil_rdata  = s_r.rdata;
	assign rd_addr       = s_axil_araddr;
	assign wr            = '{wr: s_r.wr_fire, addr: s_r.awaddr,
		data: s_r.wdata, strb: s_r.wstrb};

endmodule : hbs_axil_slave
`default_nettype wire

/* File: core/hbs_mode_ctrl.sv */
// Operating-mode controller of an H-bridge driver: active, autosleep,
// pin sleep, wake qualification and latched fault handling.
// Assumes all pins synchronous to clk; fault pins come from comparators.
//
// Summary of operation
// - The bridge stays active until a sleep entry or fault occurs.
// - Pin sleep ends only after the sleep pin is high for t_wake.
// - Autosleep ends after the drive or enable inputs are high t_wake.
// - The pinned variant has pin and auto sleep; compact only auto.
// - PWM mode with both inputs low floats outputs, sleeps after t_sleep.
// - Phase/enable with enable low brakes for t_sleep, then sleeps.
// - A low sleep pin disables the outputs and sleeps at once.
// - Leaving a sleep pattern heads back to active via t_wake from sleep, at once from idle.
// - Pin wake needs the pin high t_wake and no autosleep pattern.
// - Any fault enters fault mode; recovery returns to active, or to sleep while pin sleep is asked.
// - Interface mode comes from the tri-level strap at power-up; the compact variant is fixed PWM.
// - After retry the switches follow the inputs; a new trip repeats.
// - Half-bridge mode has no autosleep; only the sleep pin or the CTRL sleep bit sleeps.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module hbs_mode_ctrl #(
	parameter int unsigned SLEEP_CYC     = hbs_pkg::SLEEP_CYC,
	parameter int unsigned WAKE_CYC      = hbs_pkg::WAKE_CYC,
	parameter int unsigned RETRY_CYC     = hbs_pkg::RETRY_CYC,
	parameter bit          PINNED_SLEEP  = 1'b1
) (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	// AXI4-Lite register port
	input  wire logic [hbs_pkg::ADDR_W-1:0] s_axil_awaddr,
	input  wire logic                       s_axil_awvalid,
	output logic                            s_axil_awready,
	input  wire logic [31:0]                s_axil_wdata,
	input  wire logic [3:0]                 s_axil_wstrb,
	input  wire logic                       s_axil_wvalid,
	output logic                            s_axil_wready,
	output logic [1:0]                      s_axil_bresp,
	output logic                            s_axil_bvalid,
	input  wire logic                       s_axil_bready,
	input  wire logic [hbs_pkg::ADDR_W-1:0] s_axil_araddr,
	input  wire logic                       s_axil_arvalid,
	output logic                            s_axil_arready,
	output logic [31:0]                     s_axil_rdata,
	output logic [1:0]                      s_axil_rresp,
	output logic                            s_axil_rvalid,
	input  wire logic                       s_axil_rready,
	// Logic input pins
	input  wire logic                       sleep_request_low,
	input  wire logic                       drive_input_a,
	input  wire logic                       drive_input_b,
	input  wire logic                       mode_strap_high,
	input  wire logic                       mode_strap_low,
	// Analog monitor indications
	input  wire logic                       supply_low_lockout,
	input  wire logic                       overcurrent_trip,
	input  wire logic                       thermal_trip,
	input  wire logic                       thermal_clear,
	// Power stage and status
	output hbs_pkg::hbs_bridge_t            bridge_drive,
	output logic                            charge_pump_en,
	output logic                            low_power_sleep,
	output logic                            irq
);

	// ******************************
	// Local types and signals
	// ******************************
	typedef struct packed {
		hbs_pkg::hbs_state_t       st;
		hbs_pkg::hbs_mode_t        mode;
		logic                      strap_done;
		logic                      oc_lat;
		logic                      ot_lat;
		logic                      uv_prev;
		logic                      sw_sleep;
		logic [hbs_pkg::IRQ_W-1:0] irq_sts;
		logic [hbs_pkg::IRQ_W-1:0] irq_mask;
		hbs_pkg::hbs_bridge_t      bridge;
		logic                      cp_en;
		logic                      lp;
		logic                      irq;
	} hbs_main_st_t;

	localparam hbs_main_st_t MAIN_RST = '{
		st:         hbs_pkg::HBS_SLEEP,
		mode:       hbs_pkg::MODE_PWM,
		strap_done: 1'b0,
		oc_lat:     1'b0,
		ot_lat:     1'b0,
		uv_prev:    1'b0,
		sw_sleep:   1'b0,
		irq_sts:    '0,
		irq_mask:   hbs_pkg::IRQ_MASK_RST,
		bridge:     '0,
		cp_en:      1'b0,
		lp:         1'b1,
		irq:        1'b0
	};

	hbs_main_st_t                   s_r;
	hbs_main_st_t                   s_nxt;
	hbs_pkg::hbs_regacc_t           wr;
	logic [hbs_pkg::ADDR_W-1:0]     rd_addr;
	logic [31:0]                    rd_data;
	logic                           pin_sleep;
	logic                           idle_pat;
	logic                           wake_cond;
	logic                           fault_any;
	logic                           oc_evt;
	logic                           ot_evt;
	logic                           uv_evt;
	logic                           sleep_start;
	logic                           wake_start;
	logic                           sleep_done;
	logic                           wake_done;
	logic                           retry_done;
	logic [hbs_pkg::IRQ_W-1:0]      irq_evt;

	// ******************************
	// Helper functions
	// ******************************

	// Bridge drive for the present inputs in each interface mode
	function automatic hbs_pkg::hbs_bridge_t drive_decode(
		input hbs_pkg::hbs_mode_t m,
		input logic               a,
		input logic               b
	);
		hbs_pkg::hbs_bridge_t d;
		d = '0;
		unique case (m)
			hbs_pkg::MODE_PWM:
				d = '{out_a_high: a && !b, out_a_low: b,
					out_b_high: b && !a, out_b_low: a};
			hbs_pkg::MODE_PHEN:
				d = '{out_a_high: b && a, out_a_low: !(b && a),
					out_b_high: b && !a, out_b_low: !(b && !a)};
			hbs_pkg::MODE_HALF:
				d = '{out_a_high: a, out_a_low: !a,
					out_b_high: b, out_b_low: !b};
			default:
				d = '0;
		endcase
		return d;
	endfunction : drive_decode

	// Tri-level strap: both low means floating
	function automatic hbs_pkg::hbs_mode_t strap_decode(
		input logic hi,
		input logic lo
	);
		if (hi && !lo)
			return hbs_pkg::MODE_PHEN;
		else if (!hi && !lo)
			return hbs_pkg::MODE_HALF;
		else
			return hbs_pkg::MODE_PWM;
	endfunction : strap_decode

	// ******************************
	// Register bus
	// ******************************
	hbs_axil_slave u_bus (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.s_axil_awaddr  (s_axil_awaddr),
		.s_axil_awvalid (s_axil_awvalid),
		.s_axil_awready (s_axil_awready),
		.s_axil_wdata   (s_axil_wdata),
		.s_axil_wstrb   (s_axil_wstrb),
		.s_axil_wvalid  (s_axil_wvalid),
		.s_axil_wready  (s_axil_wready),
		.s_axil_bresp   (s_axil_bresp),
		.s_axil_bvalid  (s_axil_bvalid),
		.s_axil_bready  (s_axil_bready),
		.s_axil_araddr  (s_axil_araddr),
		.s_axil_arvalid (s_axil_arvalid),
		.s_axil_arready (s_axil_arready),
		.s_axil_rdata   (s_axil_rdata),
		.s_axil_rresp   (s_axil_rresp),
		.s_axil_rvalid  (s_axil_rvalid),
		.s_axil_rready  (s_axil_rready),
		.wr             (wr),
		.rd_addr        (rd_addr),
		.rd_data        (rd_data)
	);

	// Read mux; unmapped words read zero
	always_comb
	begin
		rd_data = '0;
		unique case (rd_addr)
			hbs_pkg::OFS_CTRL:
				rd_data[hbs_pkg::CTRL_SLEEP_BIT] = s_r.sw_sleep;
			hbs_pkg::OFS_STATUS:
			begin
				rd_data[hbs_pkg::STS_STATE_LSB +: 3] = s_r.st;
				rd_data[hbs_pkg::STS_MODE_LSB +: 2]  = s_r.mode;
				rd_data[hbs_pkg::STS_UV_BIT]         = supply_low_lockout;
				rd_data[hbs_pkg::STS_OC_BIT]         = s_r.oc_lat;
				rd_data[hbs_pkg::STS_OT_BIT]         = s_r.ot_lat;
				rd_data[hbs_pkg::STS_PIN_BIT]        = pin_sleep;
			end
			hbs_pkg::OFS_IRQ_STS:
				rd_data[hbs_pkg::IRQ_W-1:0] = s_r.irq_sts;
			hbs_pkg::OFS_IRQ_MASK:
				rd_data[hbs_pkg::IRQ_W-1:0] = s_r.irq_mask;
			default:
				rd_data = '0;
		endcase
	end

	// ******************************
	// Interval timers
	// ******************************
	hbs_timer #(.W(hbs_pkg::TMR_W)) u_sleep_tmr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (sleep_start),
		.len     (hbs_pkg::TMR_W'(SLEEP_CYC)),
		.done    (sleep_done)
	);

	hbs_timer #(.W(hbs_pkg::TMR_W)) u_wake_tmr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (wake_start),
		.len     (hbs_pkg::TMR_W'(WAKE_CYC)),
		.done    (wake_done)
	);

	hbs_timer #(.W(hbs_pkg::TMR_W)) u_retry_tmr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (oc_evt),
		.len     (hbs_pkg::TMR_W'(RETRY_CYC)),
		.done    (retry_done)
	);

	// ******************************
	// Pin patterns and fault detection
	// ******************************

	// Sleep pin exists only on the pinned variant
	assign pin_sleep = PINNED_SLEEP && (!sleep_request_low || s_r.sw_sleep);

	// Autosleep patterns per interface mode
	always_comb
	begin
		unique case (s_r.mode)
			hbs_pkg::MODE_PWM:
				idle_pat = !drive_input_a && !drive_input_b;
			hbs_pkg::MODE_PHEN:
				idle_pat = !drive_input_b;
			hbs_pkg::MODE_HALF:
				idle_pat = 1'b0;
			default:
				idle_pat = 1'b0;
		endcase
	end

	// Wake wants no sleep pattern at all
	assign wake_cond = !pin_sleep && !idle_pat;

	// Fault events and any-fault level
	assign oc_evt    = overcurrent_trip && !s_r.oc_lat;
	assign ot_evt    = thermal_trip && !s_r.ot_lat;
	assign uv_evt    = supply_low_lockout && !s_r.uv_prev;
	assign fault_any = supply_low_lockout || s_r.oc_lat || oc_evt ||
		s_r.ot_lat || thermal_trip;

	// Timer starts on state entry
	assign sleep_start = s_r.strap_done && !fault_any && !pin_sleep &&
		idle_pat && (s_r.st == hbs_pkg::HBS_ACTIVE);
	assign wake_start = s_r.strap_done && !fault_any && wake_cond &&
		(s_r.st == hbs_pkg::HBS_SLEEP);

	// ******************************
	// Next state
	// ******************************
	always_comb
	begin
		s_nxt = s_r;
		irq_evt = '0;

		// Strap taken once, first cycle after reset
		if (!s_r.strap_done)
		begin
			s_nxt.strap_done = 1'b1;
			s_nxt.mode = PINNED_SLEEP ?
				strap_decode(mode_strap_high, mode_strap_low) :
				hbs_pkg::MODE_PWM;
		end

		// Fault latches
		s_nxt.uv_prev = supply_low_lockout;
		if (oc_evt)
			s_nxt.oc_lat = 1'b1;
		else if (retry_done)
			s_nxt.oc_lat = 1'b0;
		if (thermal_trip)
			s_nxt.ot_lat = 1'b1;
		else if (thermal_clear)
			s_nxt.ot_lat = 1'b0;

		// Mode state machine
		if (s_r.strap_done)
		begin
			if (fault_any)
				s_nxt.st = hbs_pkg::HBS_FAULT;
			else
			begin
				unique case (s_r.st)
					hbs_pkg::HBS_ACTIVE:
						if (pin_sleep)
							s_nxt.st = hbs_pkg::HBS_SLEEP;
						else if (idle_pat)
							s_nxt.st = hbs_pkg::HBS_IDLE;
					hbs_pkg::HBS_IDLE:
						if (pin_sleep)
							s_nxt.st = hbs_pkg::HBS_SLEEP;
						else if (!idle_pat)
							s_nxt.st = hbs_pkg::HBS_ACTIVE;
						else if (sleep_done)
							s_nxt.st = hbs_pkg::HBS_SLEEP;
					hbs_pkg::HBS_SLEEP:
						if (wake_cond)
							s_nxt.st = hbs_pkg::HBS_WAKE;
					hbs_pkg::HBS_WAKE:
						if (!wake_cond)
							s_nxt.st = hbs_pkg::HBS_SLEEP;
						else if (wake_done)
							s_nxt.st = hbs_pkg::HBS_ACTIVE;
					hbs_pkg::HBS_FAULT:
						if (pin_sleep)
							s_nxt.st = hbs_pkg::HBS_SLEEP;
						else
							s_nxt.st = hbs_pkg::HBS_ACTIVE;
					default:
						s_nxt.st = hbs_pkg::HBS_SLEEP;
				endcase
			end
		end

		// Outputs for the coming state
		unique case (s_nxt.st)
			hbs_pkg::HBS_ACTIVE:
				s_nxt.bridge = drive_decode(s_nxt.mode,
					drive_input_a, drive_input_b);
			hbs_pkg::HBS_IDLE:
				s_nxt.bridge = (s_nxt.mode == hbs_pkg::MODE_PHEN) ?
					'{out_a_high: 1'b0, out_a_low: 1'b1,
					out_b_high: 1'b0, out_b_low: 1'b1} : '0;
			default:
				s_nxt.bridge = '0;
		endcase
		s_nxt.lp    = (s_nxt.st == hbs_pkg::HBS_SLEEP);
		s_nxt.cp_en = !s_nxt.lp && !supply_low_lockout;

		// Interrupt events
		irq_evt[hbs_pkg::IRQ_SLEEP] = (s_nxt.st == hbs_pkg::HBS_SLEEP) &&
			(s_r.st != hbs_pkg::HBS_SLEEP);
		irq_evt[hbs_pkg::IRQ_WAKE] = (s_nxt.st == hbs_pkg::HBS_ACTIVE) &&
			(s_r.st == hbs_pkg::HBS_WAKE);
		irq_evt[hbs_pkg::IRQ_UV] = uv_evt;
		irq_evt[hbs_pkg::IRQ_OC] = oc_evt;
		irq_evt[hbs_pkg::IRQ_OT] = ot_evt;

		// Register writes, low byte lane only
		if (wr.wr && wr.strb[0])
		begin
			unique case (wr.addr)
				hbs_pkg::OFS_CTRL:
					s_nxt.sw_sleep = wr.data[hbs_pkg::CTRL_SLEEP_BIT];
				hbs_pkg::OFS_IRQ_STS:
					s_nxt.irq_sts = s_r.irq_sts &
						~wr.data[hbs_pkg::IRQ_W-1:0];
				hbs_pkg::OFS_IRQ_MASK:
					s_nxt.irq_mask = wr.data[hbs_pkg::IRQ_W-1:0];
				default:
					s_nxt.irq_mask = s_r.irq_mask;
			endcase
		end

		// New events win over a clear in the same cycle
		s_nxt.irq_sts = s_nxt.irq_sts | irq_evt;
		s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_mask);
	end

	// ******************************
	// State register
	// ******************************
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_r <= MAIN_RST;
		else
			s_r <= s_nxt;
	end

	// Registered outputs
	assign bridge_drive    = s_r.bridge;
	assign charge_pump_en  = s_r.cp_en;
	assign low_power_sleep = s_r.lp;
	assign irq             = s_r.irq;

endmodule : hbs_mode_ctrl
`default_nettype wire

/* File: sim/hbs_mode_ctrl_sva.sv */
// Port checker of the H-bridge mode controller.
// Assumes it is bound onto hbs_mode_ctrl.
`timescale 1ns/1ps
`default_nettype none
module hbs_chk (
	input wire logic                 clk,
	input wire logic                 sys_rst,
	input wire logic                 s_axil_awvalid,
	input wire logic                 s_axil_awready,
	input wire logic                 s_axil_wvalid,
	input wire logic                 s_axil_wready,
	input wire logic                 s_axil_bvalid,
	input wire logic                 s_axil_arvalid,
	input wire logic                 s_axil_arready,
	input wire logic                 s_axil_rvalid,
	input wire logic                 sleep_request_low,
	input wire logic                 supply_low_lockout,
	input wire logic                 overcurrent_trip,
	input wire logic                 thermal_trip,
	input wire hbs_pkg::hbs_bridge_t bridge_drive,
	input wire logic                 charge_pump_en,
	input wire logic                 low_power_sleep
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Any fault indication
	wire logic flt = supply_low_lockout || overcurrent_trip || thermal_trip;
	a_pin_sleep:
		assert property (!sleep_request_low |-> ##[1:2] bridge_drive == '0)
			else $error("bridge on in pin sleep");
	a_sleep_quiet:
		assert property (low_power_sleep |-> bridge_drive == '0 &&
			!charge_pump_en) else $error("power stage on in sleep");
	a_oc_off:
		assert property (overcurrent_trip |-> ##[1:2] bridge_drive == '0)
			else $error("bridge on after overcurrent");
	a_uv_off:
		assert property (supply_low_lockout |-> ##[1:2]
			(bridge_drive == '0 && !charge_pump_en)) else $error("uv on");
	a_ot_off:
		assert property (thermal_trip |-> ##[1:2] bridge_drive == '0)
			else $error("bridge on after overtemperature");
	a_wake_hold:
		assert property ($fell(low_power_sleep) && !$past(flt) |->
			(##[0:4] flt) or (bridge_drive == '0)[*5])
			else $error("bridge on before wake time");
	a_wr_resp:
		assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid
			&& s_axil_wready |=> s_axil_bvalid) else $error("no bvalid");
	a_rd_resp:
		assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
			else $error("no rvalid");
	c_sleep: cover property ($rose(low_power_sleep));
	c_wake: cover property ($fell(low_power_sleep));
	c_oc: cover property (overcurrent_trip ##1 !overcurrent_trip);
endmodule : hbs_chk
bind hbs_mode_ctrl hbs_chk u_chk (.*);
`default_nettype wire

/* File: sim/hbs_mcu.sv */
// Controller model driving the logic pins of the bridge.
// Assumes the bench sets the wanted pattern {sleep_n, a, b}.
`timescale 1ns/1ps
`default_nettype none
module hbs_mcu #(
	parameter int HOLD = 12
) (
	input  wire logic       clk,
	input  wire logic [2:0] want,
	output logic            sleep_request_low = 1'b0,
	output logic            drive_input_a = 1'b0,
	output logic            drive_input_b = 1'b0
);
	// ****
	// Pin driver
	// ****
	int   hold_r = 0;
	wire logic st = want[2] && want[1:0] != 2'h0 && hold_r == 0 &&
		(!sleep_request_low || !(drive_input_a || drive_input_b));
	// Hold both inputs high for HOLD cycles when leaving sleep
	always @(posedge clk)
	begin
		sleep_request_low <= want[2];
		hold_r <= st ? HOLD : (hold_r > 0 ? hold_r - 1 : 0);
		drive_input_a <= st || hold_r > 1 || want[1];
		drive_input_b <= st || hold_r > 1 || want[0];
	end
endmodule : hbs_mcu
`default_nettype wire

/* File: sim/hbs_mode_ctrl_bench.sv */
// Self-checking bench of the H-bridge mode controller.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module hbs_mode_ctrl_bench;
	// ****
	// Signals
	// ****
	logic clk = 1'b0, sys_rst = 1'b1;
	logic [4:0] s_axil_awaddr = '0, s_axil_araddr = '0;
	logic [31:0] s_axil_wdata = '0, s_axil_rdata;
	logic [3:0] s_axil_wstrb = 4'hf;
	logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 1;
	logic s_axil_arvalid = 0, s_axil_rready = 1;
	logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready;
	logic s_axil_rvalid, charge_pump_en, low_power_sleep, irq;
	logic [1:0] s_axil_bresp, s_axil_rresp, v;
	logic sleep_request_low, drive_input_a, drive_input_b;
	logic mode_strap_high = 0, mode_strap_low = 1, thermal_clear = 0;
	logic supply_low_lockout = 0, overcurrent_trip = 0, thermal_trip = 0;
	logic [2:0] want = 3'h6;
	hbs_pkg::hbs_bridge_t bridge_drive;
	logic [33:0] exq[$];
	int n_mismatch = 0, checked = 0;
	hbs_mode_ctrl #(.SLEEP_CYC(20), .WAKE_CYC(8), .RETRY_CYC(16)) dut_u (.*);
	hbs_mcu #(.HOLD(12)) mcu_u (.*);
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [33:0] e, input logic [33:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %0t exp %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic br(input logic [3:0] e);
		chk(34'(e), 34'(bridge_drive));
	endtask : br
	task automatic wr(input logic [4:0] a, input logic [31:0] d,
		input logic [1:0] r);
		exq.push_back({r, 32'h0});
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axil_awvalid && s_axil_awready)
				s_axil_awvalid <= 1'b0;
			if (s_axil_wvalid && s_axil_wready)
				s_axil_wvalid <= 1'b0;
		end while (!(s_axil_bvalid && s_axil_bready));
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] d,
		input logic [1:0] r);
		exq.push_back({r, d});
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axil_arvalid && s_axil_arready)
				s_axil_arvalid <= 1'b0;
		end while (!(s_axil_rvalid && s_axil_rready));
	endtask : rd
	task automatic complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	// ****
	// Processes
	// ****
	// Clock and watchdog
	initial
		forever #2.5 clk = ~clk;
	initial
	begin
		#20000;
		n_mismatch++;
		complete_run();
	end
	// Pair each bus answer with the oldest note
	always @(posedge clk)
		if ((s_axil_bvalid && s_axil_bready) || (s_axil_rvalid && s_axil_rready))
			chk(exq.pop_front(), s_axil_rvalid ?
				{s_axil_rresp, s_axil_rdata} : {s_axil_bresp, 32'h0});
	// Main sequence
	initial
	begin
		void'($urandom(32'hc048));
		tick(5);
		sys_rst <= 1'b0;
		tick(40);
		br(4'h9);
		rd(hbs_pkg::OFS_IRQ_STS, 32'h2, 2'h0);
		wr(hbs_pkg::OFS_IRQ_MASK, 32'h1f, 2'h0);
		rd(hbs_pkg::OFS_IRQ_MASK, 32'h1f, 2'h0);
		rd(5'h10, 32'h0, 2'h2);
		wr(hbs_pkg::OFS_IRQ_STS, 32'h2, 2'h0);
		wr(5'h14, 32'h1, 2'h2);
		tick(3);
		chk(34'(irq), 34'h0);
		repeat (8)
		begin
			v = 2'($urandom_range(3, 1));
			want <= {1'b1, v};
			tick(4);
			br(v == 2'h1 ? 4'h6 : (v == 2'h2 ? 4'h9 : 4'h5));
		end
		want <= 3'h4;
		tick(3);
		br(4'h0);
		tick(30);
		chk(34'({low_power_sleep, charge_pump_en, irq}), 34'h5);
		want <= 3'h6;
		tick(5);
		br(4'h0);
		tick(25);
		br(4'h9);
		want <= 3'h2;
		tick(3);
		chk(34'(low_power_sleep), 34'h1);
		want <= 3'h6;
		tick(25);
		br(4'h9);
		overcurrent_trip <= 1'b1;
		tick(3);
		br(4'h0);
		overcurrent_trip <= 1'b0;
		tick(25);
		br(4'h9);
		supply_low_lockout <= 1'b1;
		tick(3);
		chk(34'(charge_pump_en), 34'h0);
		supply_low_lockout <= 1'b0;
		tick(4);
		br(4'h9);
		thermal_trip <= 1'b1;
		tick(3);
		thermal_trip <= 1'b0;
		tick(6);
		br(4'h0);
		thermal_clear <= 1'b1;
		tick(4);
		br(4'h9);
		thermal_clear <= 1'b0;
		rd(hbs_pkg::OFS_IRQ_STS, 32'h1f, 2'h0);
		wr(hbs_pkg::OFS_IRQ_STS, 32'h1f, 2'h0);
		tick(3);
		chk(34'(irq), 34'h0);
		// Second power-up in phase/enable mode
		mode_strap_high <= 1'b1;
		mode_strap_low <= 1'b0;
		want <= 3'h7;
		sys_rst <= 1'b1;
		tick(5);
		sys_rst <= 1'b0;
		tick(20);
		br(4'h9);
		rd(hbs_pkg::OFS_STATUS, 32'h8, 2'h0);
		want <= 3'h6;
		tick(3);
		br(4'h5);
		tick(25);
		chk(34'(low_power_sleep), 34'h1);
		complete_run();
	end
endmodule : hbs_mode_ctrl_bench
`default_nettype wire
